// ==== ptd_pkg.sv ====
// Functional notes
// - separate unsigned 7-bit pulse threshold held for X, Y and Z.
// - threshold LSB is 0.063 g on fixed 8 g scale, range select ignored.
// - axis starts pulse detection only when its magnitude exceeds its threshold.
// - pulse qualifies if it falls below threshold within time-limit count times step.
// - time-limit and latency counters are 8 bits; longest interval is step times 255.
// - time-limit step with high-pass on follows the per-rate, per-mode table.
// - time-limit step with high-pass off follows its own smaller table.
// - after a detected pulse, new pulse starts ignored for latency count times step.
// - latency step with high-pass on is twice the matching time-limit step.
// - latency step with high-pass off is twice the matching time-limit step.
// - 400 Hz normal, high-pass off, time-limit ticks every 0.625 ms.
// - hybrid mode halves the effective rate, doubling every step.
// - second-pulse window starts counting when latency interval ends.
`default_nettype none
package ptd_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] PTD_OFF_THRESH_X = 8'h23;
  localparam logic [7:0] PTD_OFF_THRESH_Y = 8'h24;
  localparam logic [7:0] PTD_OFF_THRESH_Z = 8'h25;
  localparam logic [7:0] PTD_OFF_TMLT     = 8'h26;
  localparam logic [7:0] PTD_OFF_LTCY     = 8'h27;

  // reset values and field layout
  localparam logic [6:0] PTD_THRESH_RST = 7'h00;
  localparam logic [7:0] PTD_COUNT_RST  = 8'h00;
  localparam int         PTD_THRESH_W   = 7;
  localparam int         PTD_COUNT_W    = 8;
  localparam int         PTD_MULT_W     = 12;
  localparam logic [7:0] PTD_COUNT_MAX  = 8'hFF;

  // smallest step, in ns, and clock period; every step is a multiple of it
  localparam int PTD_BASE_STEP_NS = 625000;
  localparam int PTD_CLK_NS       = 100;
  localparam int PTD_BASE_CYCLES  = PTD_BASE_STEP_NS / PTD_CLK_NS;

  // rate select: 0=800,1=400,2=200,3=100,4=50,5=12.5,6=6.25,7=1.56 Hz
  localparam logic [2:0] PTD_ODR_800  = 3'h0;
  localparam logic [2:0] PTD_ODR_50   = 3'h4;
  localparam logic [2:0] PTD_ODR_12P5 = 3'h5;

  typedef enum logic [1:0] {
    PTD_OS_NORMAL = 2'h0,
    PTD_OS_LOW_POWER_LOW_NOISE_MODE   = 2'h1,
    PTD_OS_HIRES  = 2'h2,
    PTD_OS_LOWPWR = 2'h3
  } ptd_os_mode_t;

  typedef enum logic [1:0] {
    PTD_ST_IDLE    = 2'h0,
    PTD_ST_HIGH    = 2'h1,
    PTD_ST_LATENCY = 2'h3
  } ptd_axis_state_t;

  // mode configuration seen by the timing logic
  typedef struct packed {
    logic [2:0]   odrSel;
    ptd_os_mode_t osMode;
    logic         hpfEnable;
    logic         hybridMode;
  } ptd_mode_cfg_t;

  // one acceleration sample, 8 g scale, signed
  typedef struct packed {
    logic       valid;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
  } ptd_sample_t;

  // per-axis detector state
  typedef struct packed {
    ptd_axis_state_t state;
    logic [7:0]      count;
  } ptd_axis_t;

  // time-limit step in units of 0.625 ms
  function automatic logic [PTD_MULT_W-1:0] ptd_tmlt_units(input ptd_mode_cfg_t cfg);
    logic [PTD_MULT_W-1:0] u;
    logic                  fast;
    u    = 12'h001;
    fast = (cfg.odrSel <= PTD_ODR_50);
    if (cfg.hpfEnable) begin
      case (cfg.osMode)
        PTD_OS_HIRES:  u = (cfg.odrSel == PTD_ODR_800) ? 12'h002 : 12'h004;
        PTD_OS_LOW_POWER_LOW_NOISE_MODE:   u = fast ? (12'h002 << cfg.odrSel) : 12'h080;
        PTD_OS_LOWPWR: u = fast ? (12'h002 << cfg.odrSel) :
                           (cfg.odrSel == PTD_ODR_12P5) ? 12'h080 : 12'h100;
        default:       u = fast ? (12'h002 << cfg.odrSel) : 12'h020;
      endcase
    end else begin
      case (cfg.osMode)
        PTD_OS_HIRES:  u = 12'h001;
        PTD_OS_LOWPWR: u = fast ? (12'h001 << cfg.odrSel) : 12'h040;
        PTD_OS_LOW_POWER_LOW_NOISE_MODE:   u = (cfg.odrSel == PTD_ODR_800) ? 12'h001 :
                           fast ? (12'h001 << (cfg.odrSel - 3'h1)) : 12'h020;
        default:       u = (cfg.odrSel == PTD_ODR_800) ? 12'h001 :
                           fast ? (12'h001 << (cfg.odrSel - 3'h1)) : 12'h008;
      endcase
    end
    if (cfg.hybridMode) begin
      u = u << 1;
    end
    return u;
  endfunction

  // latency step is twice the time-limit step in every mode
  function automatic logic [PTD_MULT_W-1:0] ptd_ltcy_units(input ptd_mode_cfg_t cfg);
    return ptd_tmlt_units(cfg) << 1;
  endfunction

  // magnitude of a signed sample, 0..128
  function automatic logic [7:0] ptd_abs(input logic [7:0] s);
    return s[7] ? (~s + 8'h01) : s;
  endfunction

endpackage
`default_nettype wire

// ==== ptd_step_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptd_step_timer #(
  parameter int BASE_CYCLES = ptd_pkg::PTD_BASE_CYCLES
) (
  // clock and reset
  input  wire logic                             core_clk,
  input  wire logic                             rst_n,
  // step length in base units
  input  wire logic [ptd_pkg::PTD_MULT_W-1:0]   stepUnits,
  // one-cycle pulse per step
  output logic                                  stepTick
);

  typedef struct packed {
    logic [15:0]                    baseCount;
    logic [ptd_pkg::PTD_MULT_W-1:0] unitCount;
    logic                           tick;
  } ptd_timer_state_t;

  localparam logic [15:0] BASE_LAST = 16'(BASE_CYCLES - 1);

  ptd_timer_state_t st;
  ptd_timer_state_t next_st;

  // base prescaler then step divider; a mode change takes effect at the next base unit, even in the middle of a step
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.baseCount >= BASE_LAST) begin
      next_st.baseCount = 16'h0000;
      if (st.unitCount + 12'h001 >= stepUnits) begin
        next_st.unitCount = '0;
        next_st.tick      = 1'b1;
      end else begin
        next_st.unitCount = st.unitCount + 12'h001;
      end
    end else begin
      next_st.baseCount = st.baseCount + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stepTick = st.tick;

endmodule // ptd_step_timer
`default_nettype wire

// ==== ptd_pulse_timing.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptd_pulse_timing #(
  parameter int BASE_CYCLES = ptd_pkg::PTD_BASE_CYCLES
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // register port
  input  wire logic [7:0]            regAddr,
  input  wire logic                  regWrite,
  input  wire logic [7:0]            regWdata,
  output logic [7:0]                 regRdata,
  // mode and samples
  input  wire ptd_pkg::ptd_mode_cfg_t modeCfg,
  input  wire ptd_pkg::ptd_sample_t  sample,
  // per-axis results, bit 0 = X
  output logic [2:0]                 pulseDetected,
  output logic [2:0]                 pulseNegative,
  output logic [2:0]                 latencyActive,
  output logic [2:0]                 windowStart
);

  typedef struct packed {
    logic [2:0][ptd_pkg::PTD_THRESH_W-1:0] thresh;
    logic [7:0]                            timeLimit;
    logic [7:0]                            latency;
    logic [7:0]                            rdata;
    ptd_pkg::ptd_axis_t [2:0]              axis;
    logic [2:0]                            detected;
    logic [2:0]                            negative;
    logic [2:0]                            blanking;
    logic [2:0]                            winStart;
  } ptd_top_state_t;

  ptd_top_state_t st;
  ptd_top_state_t next_st;
  logic           tmltTick;
  logic           ltcyTick;
  logic [2:0][7:0] axisVal;

  // separate step dividers so each counter sees its own step length
  ptd_step_timer #(.BASE_CYCLES(BASE_CYCLES)) u_tmlt_timer (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .stepUnits (ptd_pkg::ptd_tmlt_units(modeCfg)),
    .stepTick  (tmltTick)
  );

  ptd_step_timer #(.BASE_CYCLES(BASE_CYCLES)) u_ltcy_timer (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .stepUnits (ptd_pkg::ptd_ltcy_units(modeCfg)),
    .stepTick  (ltcyTick)
  );

  // one driver for the whole axis array, X in the low slot
  assign axisVal = {sample.z, sample.y, sample.x};

  // register access, then one detector per axis
  always_comb begin
    logic [7:0] mag;
    logic       above;
    mag     = 8'h00;
    above   = 1'b0;
    next_st = st;

    // writes; bit 7 of a threshold is not stored
    if (regWrite) begin
      case (regAddr)
        ptd_pkg::PTD_OFF_THRESH_X: next_st.thresh[0] = regWdata[6:0];
        ptd_pkg::PTD_OFF_THRESH_Y: next_st.thresh[1] = regWdata[6:0];
        ptd_pkg::PTD_OFF_THRESH_Z: next_st.thresh[2] = regWdata[6:0];
        ptd_pkg::PTD_OFF_TMLT:     next_st.timeLimit = regWdata;
        ptd_pkg::PTD_OFF_LTCY:     next_st.latency   = regWdata;
        default: ;
      endcase
    end

    // read data registered one cycle after the address; unmapped reads zero
    case (regAddr)
      ptd_pkg::PTD_OFF_THRESH_X: next_st.rdata = {1'b0, st.thresh[0]};
      ptd_pkg::PTD_OFF_THRESH_Y: next_st.rdata = {1'b0, st.thresh[1]};
      ptd_pkg::PTD_OFF_THRESH_Z: next_st.rdata = {1'b0, st.thresh[2]};
      ptd_pkg::PTD_OFF_TMLT:     next_st.rdata = st.timeLimit;
      ptd_pkg::PTD_OFF_LTCY:     next_st.rdata = st.latency;
      default:                   next_st.rdata = 8'h00;
    endcase

    next_st.detected = 3'b000;
    next_st.winStart = 3'b000;

    for (int a = 0; a < 3; a++) begin
      // sample is already on the fixed 8 g scale, so no range select enters here
      mag   = ptd_pkg::ptd_abs(axisVal[a]);
      above = (mag > {1'b0, st.thresh[a]});
      case (st.axis[a].state)
        ptd_pkg::PTD_ST_IDLE: begin
          if (sample.valid && above) begin
            next_st.axis[a].state = ptd_pkg::PTD_ST_HIGH;
            next_st.axis[a].count = ptd_pkg::PTD_COUNT_RST;
            next_st.negative[a]   = axisVal[a][7];
          end
        end
        ptd_pkg::PTD_ST_HIGH: begin
          if (sample.valid && !above) begin
            if (st.axis[a].count < st.timeLimit) begin
              next_st.detected[a]   = 1'b1;
              next_st.blanking[a]   = 1'b1;
              next_st.axis[a].state = ptd_pkg::PTD_ST_LATENCY;
              next_st.axis[a].count = ptd_pkg::PTD_COUNT_RST;
            end else begin
              next_st.axis[a].state = ptd_pkg::PTD_ST_IDLE;
            end
          end else if (st.axis[a].count >= st.timeLimit) begin
            // too long: drop the candidate; the next valid sample above threshold starts a new one
            next_st.axis[a].state = ptd_pkg::PTD_ST_IDLE;
          end else if (tmltTick && st.axis[a].count != ptd_pkg::PTD_COUNT_MAX) begin
            next_st.axis[a].count = st.axis[a].count + 8'h01;
          end
        end
        ptd_pkg::PTD_ST_LATENCY: begin
          // new starts ignored here on purpose
          if (st.axis[a].count >= st.latency) begin
            next_st.axis[a].state = ptd_pkg::PTD_ST_IDLE;
            next_st.blanking[a]   = 1'b0;
            next_st.winStart[a]   = 1'b1;
          end else if (ltcyTick && st.axis[a].count != ptd_pkg::PTD_COUNT_MAX) begin
            next_st.axis[a].count = st.axis[a].count + 8'h01;
          end
        end
        default: begin
          next_st.axis[a].state = ptd_pkg::PTD_ST_IDLE;
          next_st.blanking[a]   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops
  assign regRdata      = st.rdata;
  assign pulseDetected = st.detected;
  assign pulseNegative = st.negative;
  assign latencyActive = st.blanking;
  assign windowStart   = st.winStart;

endmodule // ptd_pulse_timing
`default_nettype wire

// ==== ptd_pulse_timing_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptd_pulse_timing_props #(
  parameter int BASE_CYCLES = ptd_pkg::PTD_BASE_CYCLES
) (
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  // register port
  input wire logic [7:0]             regAddr,
  input wire logic                   regWrite,
  input wire logic [7:0]             regWdata,
  input wire logic [7:0]             regRdata,
  // mode, samples and results
  input wire ptd_pkg::ptd_mode_cfg_t modeCfg,
  input wire ptd_pkg::ptd_sample_t   sample,
  input wire logic [2:0]             pulseDetected,
  input wire logic [2:0]             pulseNegative,
  input wire logic [2:0]             latencyActive,
  input wire logic [2:0]             windowStart
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // register port: readback, dropped top bit, unmapped space
  a_write_readback: assert property ((regWrite && regAddr == 8'h26 ##1
    !regWrite && regAddr == 8'h26) |=> regRdata == $past(regWdata, 2))
    else $error("time-limit readback wrong");
  a_thresh_top_zero: assert property (regAddr inside {8'h23, 8'h24, 8'h25} |=> !regRdata[7])
    else $error("threshold top bit not zero");
  a_unmapped_zero: assert property (!(regAddr inside {[8'h23:8'h27]}) |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  // detector outputs tied to their causes
  a_detect_needs_sample: assert property (|pulseDetected |-> $past(sample.valid))
    else $error("detect without a sample");
  a_detect_single: assert property ((pulseDetected & $past(pulseDetected)) == 3'h0)
    else $error("detect longer than one cycle");
  a_detect_blanks: assert property ((pulseDetected & ~latencyActive) == 3'h0)
    else $error("detect without latency");
  a_no_detect_blanked: assert property ((pulseDetected & $past(latencyActive)) == 3'h0)
    else $error("detect during latency");
  a_window_at_end: assert property (windowStart == ($past(latencyActive) & ~latencyActive))
    else $error("window start not at latency end");
  a_window_one_cycle: assert property ($fell(latencyActive[0]) |=> !windowStart[0])
    else $error("window start too long");
endmodule // ptd_pulse_timing_props
bind ptd_pulse_timing ptd_pulse_timing_props #(.BASE_CYCLES(BASE_CYCLES)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
  .regWdata(regWdata), .regRdata(regRdata), .modeCfg(modeCfg), .sample(sample),
  .pulseDetected(pulseDetected), .pulseNegative(pulseNegative),
  .latencyActive(latencyActive), .windowStart(windowStart));
`default_nettype wire

// ==== pulse_detect_timing_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module pulse_detect_timing_bench;
  // short base step keeps every count small
  localparam int          BASE = 4;
  logic                   core_clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic [7:0]             regAddr = 8'h00;
  logic                   regWrite = 1'b0;
  logic [7:0]             regWdata = 8'h00;
  logic [7:0]             regRdata;
  ptd_pkg::ptd_mode_cfg_t modeCfg = '0;
  ptd_pkg::ptd_sample_t   sample = '0;
  logic [2:0]             pulseDetected, pulseNegative, latencyActive, windowStart;
  int                     failures = 0;
  int                     check_count = 0;
  int                     latCycles;
  logic                   winSeen;
  logic [7:0] adr [7] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h22};
  logic [7:0] wv  [7] = '{8'hFF, 8'h55, 8'h2A, 8'h03, 8'h02, 8'hFF, 8'hFF};
  logic [7:0] rv  [7] = '{8'h7F, 8'h55, 8'h2A, 8'h03, 8'h02, 8'h00, 8'h00};

  ptd_pulse_timing #(.BASE_CYCLES(BASE)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .modeCfg(modeCfg), .sample(sample),
    .pulseDetected(pulseDetected), .pulseNegative(pulseNegative),
    .latencyActive(latencyActive), .windowStart(windowStart));

  // 100 ns period
  always #50 core_clk = ~core_clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // write strobe lasts exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regAddr = a;
    regWrite = 1'b1;
    regWdata = d;
    @(negedge core_clk);
    regWrite = 1'b0;
  endtask

  // entered at a falling edge; data settles two edges later
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    regAddr = a;
    repeat (2) @(negedge core_clk);
    chk(regRdata, exp);
  endtask

  // crossing sample, gap idle cycles, then a zero sample
  task automatic pulse(input int ax, input logic [7:0] amp, input int gap, input logic exp);
    logic hit;
    hit = 1'b0;
    @(negedge core_clk);
    sample.valid = 1'b1;
    sample.x = (ax == 0) ? amp : 8'h00;
    sample.y = (ax == 1) ? amp : 8'h00;
    sample.z = (ax == 2) ? amp : 8'h00;
    @(negedge core_clk);
    sample = '0;
    repeat (gap) @(negedge core_clk);
    sample.valid = 1'b1;
    @(negedge core_clk);
    sample.valid = 1'b0;
    hit = pulseDetected[ax]; // detect stands one cycle only
    repeat (2) begin
      @(negedge core_clk);
      hit |= pulseDetected[ax];
    end
    chk({7'h00, hit}, {7'h00, exp});
  endtask

  // wait out blanking, bounded; window pulse lands as it drops
  task automatic settle(input int ax);
    latCycles = 0;
    winSeen = 1'b0;
    while (latencyActive[ax] === 1'b1 && latCycles < 5000) begin
      @(negedge core_clk);
      latCycles++;
    end
    winSeen = windowStart[ax];
    chk({7'h00, latCycles >= 5000}, 8'h00);
  endtask

  // latency 2 lasts one to two steps; u is the latency step in 0.625 ms units
  task automatic span(input ptd_pkg::ptd_os_mode_t os, input logic [2:0] odr, input logic hp,
                      input int u);
    modeCfg.osMode = os;
    modeCfg.odrSel = odr;
    modeCfg.hpfEnable = hp;
    pulse(0, 8'h20, 1, 1'b1);
    settle(0);
    chk({7'h00, latCycles >= BASE * u - 1 && latCycles <= 2 * BASE * u - 2}, 8'h01);
  endtask

  initial begin
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    modeCfg.odrSel = 3'h1;
    for (int i = 0; i < 7; i++) begin
      rdchk(adr[i], 8'h00);
      wr(adr[i], wv[i]);
      rdchk(adr[i], rv[i]);
    end
    wr(8'h23, 8'h0A);
    pulse(0, 8'h0A, 1, 1'b0);
    pulse(0, 8'hF5, 1, 1'b1);
    chk({7'h00, pulseNegative[0]}, 8'h01);
    settle(0);
    chk({7'h00, latCycles >= 5 && latCycles <= 17}, 8'h01);
    chk({7'h00, winSeen}, 8'h01);
    pulse(1, 8'h50, 1, 1'b0);
    pulse(2, 8'h30, 1, 1'b1);
    chk({7'h00, pulseNegative[2]}, 8'h00);
    settle(2);
    // fall 14 cycles after crossing: only the longer high-pass and hybrid steps still qualify
    for (int m = 0; m < 3; m++) begin
      modeCfg.hpfEnable = (m == 1);
      modeCfg.hybridMode = (m == 2);
      pulse(0, 8'h20, 13, m != 0);
      settle(0);
    end
    modeCfg.hybridMode = 1'b0;
    wr(8'h26, 8'h00);
    pulse(0, 8'h20, 1, 1'b0);
    wr(8'h26, 8'h03);
    wr(8'h27, 8'h10);
    pulse(0, 8'h20, 1, 1'b1);
    pulse(0, 8'h20, 1, 1'b0);
    settle(0);
    chk({7'h00, latCycles > 80}, 8'h01);
    // the oversampling modes not yet visited, each with its own step
    wr(8'h27, 8'h02);
    span(ptd_pkg::PTD_OS_HIRES, 3'h1, 1'b1, 8);
    span(ptd_pkg::PTD_OS_LOWPWR, 3'h1, 1'b0, 4);
    span(ptd_pkg::PTD_OS_LOW_POWER_LOW_NOISE_MODE, 3'h5, 1'b0, 64);
    span(ptd_pkg::PTD_OS_LOWPWR, 3'h6, 1'b1, 512);
    give_verdict;
  end

  // hang guard, far beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    give_verdict;
  end
endmodule // pulse_detect_timing_bench
`default_nettype wire
